// >>> rtl/swrs_defs.vh
// Purpose: Shared constants for the sleep/wake rail sequencer.
// Assumes: 100 MHz clock (10 ns period).
// Notes:   The S3 delay is given in ns and its cycle count derives from it; other times are given in cycles.
`ifndef SWRS_DEFS_VH
`define SWRS_DEFS_VH

`define SWRS_CLK_PERIOD_NS   10
`define SWRS_S3_DELAY_NS     60000
`define SWRS_S3_DELAY_CYC    (`SWRS_S3_DELAY_NS / `SWRS_CLK_PERIOD_NS)
`define SWRS_SS_PERIOD_CYC   1000
`define SWRS_DGL_CYC         4
`define SWRS_WAKE_PERIODS    2'h3
`define SWRS_MAX_RETRIES     2'h3
`define SWRS_CNT_W           16

// Sleep state encodings.
`define SWRS_ST_ACTIVE       2'h0
`define SWRS_ST_S3           2'h1
`define SWRS_ST_S45          2'h2

// Regulator supervisor states.
`define SWRS_RG_OFF          3'h0
`define SWRS_RG_RAMP         3'h1
`define SWRS_RG_ON           3'h2
`define SWRS_RG_WAIT         3'h3
`define SWRS_RG_LATCH        3'h4
`define SWRS_RG_STBY         3'h5

`endif

// >>> rtl/swrs_sync.v
// Purpose: Two-flop synchroniser plus stable-count deglitch for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first flop feeds only the second flop.
`timescale 1ns/1ps
`default_nettype none
`include "swrs_defs.vh"
module swrs_sync (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  // Pins and filtered result
  input  wire [1:0] pin_in,
  output reg  [1:0] filt_q
);
  reg [1:0] meta_q;
  reg [1:0] sync_q;
  reg [7:0] stab_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      filt_q <= 2'h3;
      stab_q <= 8'h00;
    end else if (ce) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      if (sync_q == filt_q) begin
        stab_q <= 8'h00;
      end else if (stab_q == 8'd`SWRS_DGL_CYC) begin
        filt_q <= sync_q;
        stab_q <= 8'h00;
      end else begin
        stab_q <= stab_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/swrs_tick.v
// Purpose: Soft-start interval timebase.
// Assumes: One clock domain.
// Notes:   Emits a one-cycle tick each soft-start period; restart realigns it.
`timescale 1ns/1ps
`default_nettype none
`include "swrs_defs.vh"
module swrs_tick (
  // Clock and reset
  input  wire clk,
  input  wire sys_rst,
  input  wire ce,
  // Control
  input  wire restart,
  output reg  tick_q
);
  reg [`SWRS_CNT_W-1:0] cnt_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= {`SWRS_CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= 1'b0;
      if (restart) begin
        cnt_q <= {`SWRS_CNT_W{1'b0}};
      end else if (cnt_q == `SWRS_SS_PERIOD_CYC - 1) begin
        cnt_q  <= {`SWRS_CNT_W{1'b0}};
        tick_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + {{(`SWRS_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/swrs_top.v
// Purpose: Sleep/wake sequencing and regulator undervoltage retry control.
// Assumes: sys_rst is the supply power-on reset; rail12_por and aux_rail_sense come
//          from analog comparators and are synchronised here.
// Notes:   Gate-drive release is open drain; regulator enable feeds the LDO.
// Functional notes
// - After the 12V good indication on wake, three soft-start periods elapse, then all wake outputs change in one cycle.
// - At wake completion the gate-drive release pin is let go to high impedance.
// - At wake completion the sleep P-channel gate is driven high.
// - At wake completion the internal 3.3V regulator goes to standby.
// - Undervoltage is acted on only in sleep and only after the first soft-start ramp.
// - The aux rail counts as undervoltage when its comparator reports below 2.475V, 25% under nominal.
// - A qualified undervoltage disables the regulator.
// - One soft-start interval after an undervoltage shutdown the regulator restarts with a new ramp.
// - After three retries a fourth undervoltage latches the regulator off until power-on reset.
// - Overcurrent foldback reaching the undervoltage threshold takes the same shutdown and retry path.
// - Both sleep inputs high is active, only S3 low is S3, both low is S4/S5.
// - S4/S5 never moves straight to S3, and only S5 low holds the previous state.
// - Active to S3 waits 60us, active to S4/S5 is immediate, and sleep inputs are deglitched.
`timescale 1ns/1ps
`default_nettype none
`include "swrs_defs.vh"
module swrs_top (
  // Clock, reset and enable
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  // Sleep-state pins, active low
  input  wire       sleep_s3_n,
  input  wire       sleep_s5_n,
  // Analog monitors
  input  wire       rail12_por,
  input  wire       aux_rail_sense,
  // Open-drain gate-drive release
  output reg        gate_drive_release_o,
  output reg        gate_drive_release_oe,
  // Sleep P-channel gate and regulator control
  output reg        sleep_pfet_gate,
  output reg        reg_enable_q,
  output reg        reg_standby_q,
  output reg        reg_latched_q,
  output reg  [1:0] sleep_state_q
);
  wire [1:0] pins_f;
  wire [1:0] mon_f;
  wire       ss_tick;
  wire       s3_req;
  wire       s45_req;
  wire       act_req;
  wire       por12;
  wire       uv;

  reg  [1:0] state_d;
  reg [15:0] s3dly_q;
  reg  [1:0] wake_cnt_q;
  reg        waking_q;
  reg  [2:0] rg_q;
  reg  [2:0] rg_d;
  reg  [1:0] retry_q;
  reg        tick_rst;

  // Sleep pins: bit1 is the S5 input, bit0 the S3 input.
  swrs_sync u_pins (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin_in  ({sleep_s5_n, sleep_s3_n}),
    .filt_q  (pins_f)
  );

  // Comparators: bit1 is 12V good, bit0 is aux below 2.475V.
  swrs_sync u_mon (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pin_in  ({rail12_por, aux_rail_sense}),
    .filt_q  (mon_f)
  );

  swrs_tick u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .restart (tick_rst),
    .tick_q  (ss_tick)
  );

  assign act_req = pins_f[1] & pins_f[0];
  assign s3_req  = pins_f[1] & ~pins_f[0];
  assign s45_req = ~pins_f[1] & ~pins_f[0];
  assign por12   = mon_f[1];
  // Foldback and true undervoltage both show as the comparator trip.
  assign uv      = mon_f[0];

  // Sleep state decode.
  always @* begin
    state_d = sleep_state_q;
    if (s45_req) begin
      state_d = `SWRS_ST_S45;
    end else if (s3_req) begin
      if (sleep_state_q == `SWRS_ST_ACTIVE && s3dly_q == `SWRS_S3_DELAY_CYC) begin
        state_d = `SWRS_ST_S3;
      end
    end else if (act_req) begin
      state_d = `SWRS_ST_ACTIVE;
    end
    // Only S5 low: keep the previous state. S4/S5 to S3 is never taken.
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_state_q <= `SWRS_ST_S45;
      s3dly_q       <= 16'h0000;
    end else if (ce) begin
      sleep_state_q <= state_d;
      if (s3_req && sleep_state_q == `SWRS_ST_ACTIVE && s3dly_q != `SWRS_S3_DELAY_CYC) begin
        s3dly_q <= s3dly_q + 16'h0001;
      end else if (!s3_req) begin
        s3dly_q <= 16'h0000;
      end
    end
  end

  // Regulator supervisor with wake sequencing.
  always @* begin
    rg_d     = rg_q;
    tick_rst = 1'b0;
    case (rg_q)
      `SWRS_RG_OFF: begin
        if (ss_tick) begin
          rg_d = `SWRS_RG_RAMP;
        end
      end
      `SWRS_RG_RAMP: begin
        if (ss_tick) begin
          rg_d = `SWRS_RG_ON;
        end
      end
      `SWRS_RG_ON: begin
        if (sleep_state_q != `SWRS_ST_ACTIVE && uv) begin
          rg_d     = (retry_q == `SWRS_MAX_RETRIES) ? `SWRS_RG_LATCH : `SWRS_RG_WAIT;
          tick_rst = 1'b1;
        end else if (waking_q && ss_tick && wake_cnt_q == `SWRS_WAKE_PERIODS - 2'h1) begin
          rg_d = `SWRS_RG_STBY;
        end
      end
      `SWRS_RG_WAIT: begin
        if (ss_tick) begin
          rg_d = `SWRS_RG_RAMP;
        end
      end
      `SWRS_RG_LATCH: begin
        rg_d = `SWRS_RG_LATCH;
      end
      `SWRS_RG_STBY: begin
        if (sleep_state_q != `SWRS_ST_ACTIVE) begin
          rg_d     = `SWRS_RG_RAMP;
          tick_rst = 1'b1;
        end
      end
      default: begin
        rg_d = `SWRS_RG_OFF;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rg_q                  <= `SWRS_RG_OFF;
      retry_q               <= 2'h0;
      wake_cnt_q            <= 2'h0;
      waking_q              <= 1'b0;
      gate_drive_release_o  <= 1'b0;
      gate_drive_release_oe <= 1'b1;
      sleep_pfet_gate       <= 1'b1;
      reg_enable_q          <= 1'b0;
      reg_standby_q         <= 1'b0;
      reg_latched_q         <= 1'b0;
    end else if (ce) begin
      rg_q <= rg_d;
      if (rg_q == `SWRS_RG_ON && rg_d == `SWRS_RG_WAIT) begin
        retry_q <= retry_q + 2'h1;
      end
      // Wake count starts at the 12V good indication while active.
      if (sleep_state_q != `SWRS_ST_ACTIVE || !por12 || rg_q == `SWRS_RG_STBY) begin
        waking_q   <= 1'b0;
        wake_cnt_q <= 2'h0;
      end else if (!waking_q) begin
        waking_q   <= (rg_q == `SWRS_RG_ON);
        wake_cnt_q <= 2'h0;
      end else if (ss_tick) begin
        wake_cnt_q <= wake_cnt_q + 2'h1;
      end
      reg_enable_q  <= (rg_d == `SWRS_RG_RAMP) || (rg_d == `SWRS_RG_ON);
      reg_standby_q <= (rg_d == `SWRS_RG_STBY);
      reg_latched_q <= (rg_d == `SWRS_RG_LATCH);
      gate_drive_release_oe <= (rg_d != `SWRS_RG_STBY);
      gate_drive_release_o  <= 1'b0;
      if (rg_d == `SWRS_RG_STBY) begin
        sleep_pfet_gate <= 1'b1;
      end else begin
        sleep_pfet_gate <= (state_d != `SWRS_ST_S3);
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/swrs_top_sva.sv
// Purpose: Port-level checks for the sleep/wake rail sequencer.
// Assumes: Soft-start period of 1000 cycles.
// Notes:   Attached to swrs_top by bind.
`timescale 1ns/1ps
`default_nettype none
module swrs_top_sva (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Observed outputs
  input wire logic       gate_drive_release_o,
  input wire logic       gate_drive_release_oe,
  input wire logic       sleep_pfet_gate,
  input wire logic       reg_enable_q,
  input wire logic       reg_standby_q,
  input wire logic       reg_latched_q,
  input wire logic [1:0] sleep_state_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OD_LOW: assert property (gate_drive_release_o == 1'b0)
    else $error("gate drive data not low");
  AST_WAKE_TOGETHER: assert property ($fell(gate_drive_release_oe) |->
    sleep_pfet_gate && reg_standby_q && sleep_state_q == 2'h0)
    else $error("wake outputs split");
  AST_STBY_WITH_RELEASE: assert property ($rose(reg_standby_q) |-> $fell(gate_drive_release_oe))
    else $error("standby without release");
  AST_PFET_ONLY_S3: assert property (!sleep_pfet_gate |-> sleep_state_q == 2'h1)
    else $error("pfet on outside S3");
  AST_NO_S45_TO_S3: assert property ($past(sleep_state_q) == 2'h2 |-> sleep_state_q != 2'h1)
    else $error("S4/S5 moved to S3");
  AST_UV_SLEEP_ONLY: assert property ($rose(reg_latched_q) |-> sleep_state_q != 2'h0)
    else $error("latch while active");
  AST_LATCH_HOLD: assert property (reg_latched_q |=> reg_latched_q && !reg_enable_q)
    else $error("latch released");
  // Counts the cycles from a retry shutdown until the regulator comes back on.
  logic        gap_on_q;
  logic [10:0] gap_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_on_q <= 1'b0;
      gap_q    <= 11'h000;
    end else if ($fell(reg_enable_q) && !reg_standby_q && !reg_latched_q) begin
      gap_on_q <= 1'b1;
      gap_q    <= 11'h000;
    end else if (gap_on_q) begin
      gap_q <= gap_q + 11'h001;
      if (reg_enable_q || gap_q == 11'h3f1) begin
        gap_on_q <= 1'b0;
      end
    end
  end
  AST_RETRY_GAP: assert property (gap_on_q && $rose(reg_enable_q) |-> gap_q >= 11'h3dc && gap_q <= 11'h3f0)
    else $error("retry gap wrong");
  AST_RETRY_LATE: assert property (gap_on_q |-> gap_q <= 11'h3f0)
    else $error("retry too late");
  cover property ($fell(gate_drive_release_oe));
  cover property ($rose(reg_latched_q));
  cover property ($rose(sleep_state_q == 2'h1));
endmodule
bind swrs_top swrs_top_sva i_swrs_top_sva (.clk(clk), .sys_rst(sys_rst),
  .gate_drive_release_o(gate_drive_release_o), .gate_drive_release_oe(gate_drive_release_oe),
  .sleep_pfet_gate(sleep_pfet_gate), .reg_enable_q(reg_enable_q), .reg_standby_q(reg_standby_q),
  .reg_latched_q(reg_latched_q), .sleep_state_q(sleep_state_q));
`default_nettype wire

// >>> bench/swrs_far.sv
// Purpose: Board side of the gate-drive release pin.
// Assumes: External pull-up to the 12V rail.
// Notes:   A released pin reads high.
`timescale 1ns/1ps
`default_nettype none
module swrs_far (
  // Open-drain driver
  input  wire logic oe,
  input  wire logic o,
  // Resolved pin level
  output wire logic pin
);
  assign pin = oe ? o : 1'b1;
endmodule
`default_nettype wire

// >>> bench/swrs_top_tb.sv
// Purpose: Self-checking bench for swrs_top.
// Assumes: Soft-start period of 1000 cycles.
// Notes:   Each scenario task judges its own results.
`timescale 1ns/1ps
`default_nettype none
module swrs_top_tb;
  logic       clk = 0, sys_rst = 1, ce = 1, sleep_s3_n = 1, sleep_s5_n = 1;
  logic       rail12_por = 0, aux_rail_sense = 0;
  wire        gate_drive_release_o, gate_drive_release_oe, sleep_pfet_gate, pin;
  wire        reg_enable_q, reg_standby_q, reg_latched_q;
  wire  [1:0] sleep_state_q;
  int         error_cnt = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  swrs_top i_swrs_top (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sleep_s3_n(sleep_s3_n),
    .sleep_s5_n(sleep_s5_n), .rail12_por(rail12_por), .aux_rail_sense(aux_rail_sense),
    .gate_drive_release_o(gate_drive_release_o), .gate_drive_release_oe(gate_drive_release_oe),
    .sleep_pfet_gate(sleep_pfet_gate), .reg_enable_q(reg_enable_q), .reg_standby_q(reg_standby_q),
    .reg_latched_q(reg_latched_q), .sleep_state_q(sleep_state_q));
  swrs_far i_swrs_far (.oe(gate_drive_release_oe), .o(gate_drive_release_o), .pin(pin));
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [1:0] s, input logic [1:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %0t seen %b expected %b", $time, s, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = gate_drive_release_oe;
      1: pick = reg_enable_q;
      2: pick = sleep_state_q == 2'h1;
      default: pick = sleep_state_q == 2'h2;
    endcase
  endfunction
  // Bounded wait for a watched output to reach a level; n returns the cycles spent.
  task wt(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("mismatch %0t timeout", $time);
      summarize;
    end
  endtask
  task t_wake;
    chk(gate_drive_release_oe, 1); chk(sleep_pfet_gate, 1); chk(reg_enable_q, 0);
    cyc(2200);
    rail12_por = 1;
    wt(0, 0, 3200);
    chk(n > 1990 && n < 3030, 1);
    chk(pin, 1);
    chk(sleep_pfet_gate, 1);
    chk(reg_standby_q, 1);
    sleep_s5_n = 0;
    aux_rail_sense = 1;
    cyc(100);
    chk(sleep_state_q, 2'h0);
    chk(reg_latched_q, 0);
    sleep_s5_n = 1;
    aux_rail_sense = 0;
    $display("wake test done");
  endtask
  task t_sleep;
    sleep_s3_n = 0;
    cyc(5000);
    chk(sleep_state_q, 2'h0);
    wt(2, 1, 1100);
    chk(n > 995 && n < 1015, 1);
    cyc(1);
    chk(sleep_pfet_gate, 0);
    sleep_s5_n = 0;
    wt(3, 1, 20);
    sleep_s5_n = 1;
    cyc(7000);
    chk(sleep_state_q, 2'h2);
    sleep_s5_n = 0;
    cyc(20);
    ce = 0;
    sleep_s3_n = 1;
    sleep_s5_n = 1;
    cyc(50);
    chk(sleep_state_q, 2'h2);
    sleep_s3_n = 0;
    sleep_s5_n = 0;
    ce = 1;
    $display("sleep test done");
  endtask
  task t_retry;
    cyc(2100);
    for (int k = 0; k < 4; k++) begin
      aux_rail_sense = 1;
      wt(1, 0, 20);
      aux_rail_sense = 0;
      if (k < 3) begin
        chk(reg_latched_q, 0);
        wt(1, 1, 1100);
        chk(n > 985 && n < 1010, 1);
        cyc(1100);
      end
    end
    cyc(3000);
    chk(reg_latched_q, 1);
    chk(reg_enable_q, 0);
    sys_rst = 1;
    cyc(2);
    chk(reg_latched_q, 0);
    $display("retry test done");
  endtask
  initial begin
    cyc(12);
    sys_rst = 0;
    t_wake;
    t_sleep;
    t_retry;
    summarize;
  end
endmodule
`default_nettype wire
